// ==== design/adc_pkg.sv ====
// shared constants and types for the converter control block
package adc_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] ADC_RESULT_OFFSET = 8'h1e;
    localparam logic [7:0] ADC_CTRL_OFFSET = 8'h1f;
    localparam logic [7:0] ADC_PINCFG_OFFSET = 8'h9f;
    localparam logic [7:0] ADC_FLAG_OFFSET = 8'h0c;
    localparam logic [7:0] ADC_ENABLE_OFFSET = 8'h8c;

    // field positions
    localparam int ADC_DONE_BIT = 6;
    localparam int ADC_PINCFG_WIDTH = 3;

    // reset values
    localparam logic [7:0] ADC_CTRL_RESET = 8'h00;
    localparam logic [2:0] ADC_PINCFG_RESET = 3'h0;
    localparam logic [7:0] ADC_RESULT_RESET = 8'h00;

    // conversion clock selection
    typedef enum logic [1:0] {
        ADC_CLK_DIV2 = 2'h0,
        ADC_CLK_DIV8 = 2'h1,
        ADC_CLK_DIV32 = 2'h2,
        ADC_CLK_RC = 2'h3
    } adc_clk_sel_type;

    // timing, in system clock periods and nanoseconds
    localparam int ADC_TOSC_NS = 10;
    localparam int ADC_DIV2_TOSC = 2;
    localparam int ADC_DIV8_TOSC = 8;
    localparam int ADC_DIV32_TOSC = 32;
    localparam int ADC_RC_TAD_NS = 2000;
    localparam int ADC_RC_TAD_CYCLES = (ADC_RC_TAD_NS + ADC_TOSC_NS - 1) / ADC_TOSC_NS;
    localparam int ADC_RC_HALF_CYCLES = (ADC_RC_TAD_CYCLES + 1) / 2;

    // sequence lengths in half bit-conversion periods
    localparam logic [4:0] ADC_CONV_HALVES = 5'h13;
    localparam logic [4:0] ADC_FIRST_BIT_HALF = 5'h03;
    localparam logic [4:0] ADC_SETTLE_HALVES = 5'h04;

    // analog pin masks, bit n set means channel n is analog
    localparam logic [7:0] ADC_MASK_ALL = 8'hff;
    localparam logic [7:0] ADC_MASK_ALL_VREF = 8'hf7;
    localparam logic [7:0] ADC_MASK_PORTA = 8'h1f;
    localparam logic [7:0] ADC_MASK_PORTA_VREF = 8'h17;
    localparam logic [7:0] ADC_MASK_THREE = 8'h0b;
    localparam logic [7:0] ADC_MASK_TWO = 8'h03;
    localparam logic [7:0] ADC_MASK_NONE = 8'h00;

    // control register layout, bit 7 first
    typedef struct packed {
        adc_clk_sel_type clock_sel;
        logic [2:0] channel_select;
        logic go;
        logic unused;
        logic converter_power_on;
    } adc_ctrl_type;

    // signals toward the sample-and-hold front end
    typedef struct packed {
        logic [7:0] analog_mask;
        logic vref_external;
        logic [2:0] channel;
        logic sampling;
        logic powered;
        logic [7:0] trial;
    } adc_front_type;

endpackage : adc_pkg

// ==== design/adc_tad_divider.sv ====
// half bit-conversion-period enable generator
`timescale 1ns/1ps
module adc_tad_divider
    import adc_pkg::*;
#(
    parameter int RC_HALF_CYCLES = ADC_RC_HALF_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire adc_clk_sel_type clock_sel_in,
    // enable pulse
    output logic half_tick_out
);

    logic [7:0] count_reg;
    logic [7:0] count_next;
    wire logic [7:0] limit;

    // 2, 8 or 32 oscillator periods per bit, or the rc period
    assign limit = (clock_sel_in == ADC_CLK_DIV2) ? 8'(ADC_DIV2_TOSC / 2 - 1) :
                   (clock_sel_in == ADC_CLK_DIV8) ? 8'(ADC_DIV8_TOSC / 2 - 1) :
                   (clock_sel_in == ADC_CLK_DIV32) ? 8'(ADC_DIV32_TOSC / 2 - 1) :
                   8'(RC_HALF_CYCLES - 1);
    assign half_tick_out = run_in && (count_reg == limit);
    // restarting from zero keeps the phase tied to the sequence start
    assign count_next = (!run_in || half_tick_out) ? 8'h00 : count_reg + 8'h01;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            count_reg <= 8'h00;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule : adc_tad_divider

// ==== design/adc_sar.sv ====
// successive approximation register
`timescale 1ns/1ps
module adc_sar
    import adc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // sequencing
    input wire logic clear_in,
    input wire logic step_in,
    input wire logic compare_in,
    // trial word
    output logic [WIDTH-1:0] trial_out
);

    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] trial_next;
    logic [WIDTH-1:0] mask_next;
    wire logic [WIDTH-1:0] top_bit;
    wire logic [WIDTH-1:0] kept;

    assign top_bit = {1'b1, {(WIDTH - 1){1'b0}}};
    // a low comparator answer means the input sits below the trial level
    assign kept = compare_in ? trial_out : (trial_out & ~mask_reg);

    always_comb begin
        trial_next = trial_out;
        mask_next = mask_reg;
        if (clear_in) begin
            trial_next = top_bit;
            mask_next = top_bit;
        end else if (step_in && (mask_reg != '0)) begin
            trial_next = kept | (mask_reg >> 1);
            mask_next = mask_reg >> 1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            trial_out <= '0;
            mask_reg <= '0;
        end else begin
            trial_out <= trial_next;
            mask_reg <= mask_next;
        end
    end

endmodule : adc_sar

// ==== design/adc_control.sv ====
// converter control, port configuration and conversion sequencer
`timescale 1ns/1ps
module adc_control
    import adc_pkg::*;
#(
    parameter int CHANNEL_COUNT = 8,
    parameter int RC_HALF_CYCLES = ADC_RC_HALF_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // analog front end
    input wire logic compare_in,
    output adc_front_type front_out,
    // completion interrupt request
    output logic conv_done_irq_out
);

    // reset image of the control register, for the frozen copies
    localparam adc_ctrl_type CTRL_RESET = adc_ctrl_type'(ADC_CTRL_RESET);

    typedef enum {
        ST_IDLE,
        ST_CONVERT,
        ST_SETTLE
    } adc_state_type;

    adc_state_type state_reg;
    adc_state_type state_next;
    adc_ctrl_type ctrl_reg;
    adc_ctrl_type ctrl_next;
    logic [2:0] pincfg_reg;
    logic [2:0] pincfg_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic conv_done_flag_reg;
    logic conv_done_flag_next;
    logic conv_done_irq_enable_reg;
    logic conv_done_irq_enable_next;
    logic [4:0] half_count_reg;
    logic [4:0] half_count_next;
    logic sar_clear;
    logic [7:0] rdata_next;
    adc_front_type front_next;
    adc_clk_sel_type held_clk_reg;
    logic [2:0] held_channel_reg;

    wire logic half_tick;
    wire logic [7:0] trial;
    wire adc_ctrl_type wr_ctrl;
    wire logic wr_ctrl_hit;
    wire logic wr_pincfg_hit;
    wire logic wr_result_hit;
    wire logic wr_flag_hit;
    wire logic wr_enable_hit;
    wire logic go_request;
    wire logic go_cancel;
    wire logic finishing;
    wire logic aborting;
    wire logic bit_step;
    wire logic divider_run;
    wire logic [7:0] variant_mask;
    wire logic [7:0] analog_mask;
    wire logic vref_external;
    wire adc_clk_sel_type held_clk_next;
    wire logic [2:0] held_channel_next;
    wire logic [2:0] front_channel;

    // address decode
    assign wr_ctrl = adc_ctrl_type'(reg_wdata_in);
    assign wr_ctrl_hit = reg_write_in && (reg_addr_in == ADC_CTRL_OFFSET);
    assign wr_pincfg_hit = reg_write_in && (reg_addr_in == ADC_PINCFG_OFFSET);
    assign wr_result_hit = reg_write_in && (reg_addr_in == ADC_RESULT_OFFSET);
    assign wr_flag_hit = reg_write_in && (reg_addr_in == ADC_FLAG_OFFSET);
    assign wr_enable_hit = reg_write_in && (reg_addr_in == ADC_ENABLE_OFFSET);

    // a start needs the converter already powered, so power and go in one write powers up without starting
    assign go_request = wr_ctrl_hit && wr_ctrl.go && wr_ctrl.converter_power_on
                        && ctrl_reg.converter_power_on;
    // switching the converter off drops go as well, so go never reads one while unpowered
    assign go_cancel = (wr_ctrl_hit && !wr_ctrl.go) || (wr_ctrl_hit && !wr_ctrl.converter_power_on);

    // sequencer events
    assign finishing = (state_reg == ST_CONVERT) && half_tick
                       && (half_count_reg == ADC_CONV_HALVES - 5'h01);
    assign aborting = (state_reg == ST_CONVERT) && go_cancel && !finishing;
    assign bit_step = (state_reg == ST_CONVERT) && half_tick && half_count_reg[0]
                      && (half_count_reg >= ADC_FIRST_BIT_HALF);
    assign divider_run = (state_reg != ST_IDLE) && !aborting;

    // analog pin map per configuration setting
    assign analog_mask = (pincfg_reg == 3'h0) ? ADC_MASK_ALL :
                         (pincfg_reg == 3'h1) ? ADC_MASK_ALL_VREF :
                         (pincfg_reg == 3'h2) ? ADC_MASK_PORTA :
                         (pincfg_reg == 3'h3) ? ADC_MASK_PORTA_VREF :
                         (pincfg_reg == 3'h4) ? ADC_MASK_THREE :
                         (pincfg_reg == 3'h5) ? ADC_MASK_TWO :
                         ADC_MASK_NONE;
    // odd settings below 110 take the reference from the shared pin
    assign vref_external = pincfg_reg[0] && (pincfg_reg[2:1] != 2'h3);
    // channels above the variant's count never become analog
    assign variant_mask = 8'((9'h001 << CHANNEL_COUNT) - 9'h001);

    // conversion settings are frozen at the start: a clock change mid-conversion could leave
    // the divider count above its new limit, and a channel change would move the sample switch
    assign held_clk_next = sar_clear ? ctrl_reg.clock_sel : held_clk_reg;
    assign held_channel_next = sar_clear ? ctrl_reg.channel_select : held_channel_reg;
    assign front_channel = (state_reg == ST_CONVERT) ? held_channel_reg : ctrl_reg.channel_select;

    // the divider follows the select frozen at the start
    adc_tad_divider #(
        .RC_HALF_CYCLES(RC_HALF_CYCLES)
    ) u_divider (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .run_in(divider_run),
        .clock_sel_in(held_clk_reg),
        .half_tick_out(half_tick)
    );

    adc_sar #(
        .WIDTH(8)
    ) u_sar (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clear_in(sar_clear),
        .step_in(bit_step),
        .compare_in(compare_in),
        .trial_out(trial)
    );

    // sequencer
    // a go set during settle is held and starts the next conversion once idle
    always_comb begin
        state_next = state_reg;
        half_count_next = half_count_reg;
        sar_clear = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                half_count_next = 5'h00;
                if (ctrl_reg.go && ctrl_reg.converter_power_on) begin
                    state_next = ST_CONVERT;
                    sar_clear = 1'b1;
                end
            end
            ST_CONVERT: begin
                if (aborting || finishing) begin
                    state_next = ST_SETTLE;
                    half_count_next = 5'h00;
                end else if (half_tick) begin
                    half_count_next = half_count_reg + 5'h01;
                end
            end
            ST_SETTLE: begin
                if (half_tick) begin
                    half_count_next = half_count_reg + 5'h01;
                    if (half_count_reg == ADC_SETTLE_HALVES - 5'h01) begin
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // control and configuration registers
    always_comb begin
        ctrl_next = ctrl_reg;
        pincfg_next = pincfg_reg;
        result_next = result_reg;
        conv_done_irq_enable_next = conv_done_irq_enable_reg;
        conv_done_flag_next = conv_done_flag_reg;
        if (wr_ctrl_hit) begin
            ctrl_next.clock_sel = wr_ctrl.clock_sel;
            ctrl_next.channel_select = wr_ctrl.channel_select;
            ctrl_next.converter_power_on = wr_ctrl.converter_power_on;
            ctrl_next.go = go_request || (ctrl_reg.go && !go_cancel);
        end
        if (wr_pincfg_hit) begin
            pincfg_next = reg_wdata_in[ADC_PINCFG_WIDTH-1:0];
        end
        if (wr_result_hit) begin
            result_next = reg_wdata_in;
        end
        if (wr_enable_hit) begin
            conv_done_irq_enable_next = reg_wdata_in[ADC_DONE_BIT];
        end
        if (wr_flag_hit) begin
            conv_done_flag_next = reg_wdata_in[ADC_DONE_BIT];
        end
        if (finishing) begin
            // completion overrides a same-cycle write of the flag or the result
            ctrl_next.go = 1'b0;
            result_next = trial;
            conv_done_flag_next = 1'b1;
        end
        ctrl_next.unused = 1'b0;
    end

    // front end drive, registered into front_out below
    always_comb begin
        front_next.analog_mask = analog_mask & variant_mask;
        front_next.vref_external = vref_external;
        front_next.channel = front_channel;
        front_next.powered = ctrl_reg.converter_power_on;
        front_next.sampling = ctrl_reg.converter_power_on && (state_next == ST_IDLE);
        front_next.trial = trial;
    end

    // read data mux, registered for the one-cycle answer
    always_comb begin
        rdata_next = 8'h00;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                ADC_CTRL_OFFSET: rdata_next = ctrl_reg;
                ADC_PINCFG_OFFSET: rdata_next = {5'h00, pincfg_reg};
                ADC_RESULT_OFFSET: rdata_next = result_reg;
                ADC_FLAG_OFFSET: rdata_next = 8'(conv_done_flag_reg) << ADC_DONE_BIT;
                ADC_ENABLE_OFFSET: rdata_next = 8'(conv_done_irq_enable_reg) << ADC_DONE_BIT;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            half_count_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            half_count_reg <= half_count_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_reg <= adc_ctrl_type'(ADC_CTRL_RESET);
            pincfg_reg <= ADC_PINCFG_RESET;
            result_reg <= ADC_RESULT_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            pincfg_reg <= pincfg_next;
            result_reg <= result_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            conv_done_flag_reg <= 1'b0;
            conv_done_irq_enable_reg <= 1'b0;
            conv_done_irq_out <= 1'b0;
        end else begin
            conv_done_flag_reg <= conv_done_flag_next;
            conv_done_irq_enable_reg <= conv_done_irq_enable_next;
            conv_done_irq_out <= conv_done_flag_next && conv_done_irq_enable_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            front_out <= '0;
        end else begin
            reg_rdata_out <= rdata_next;
            front_out <= front_next;
        end
    end

    // frozen conversion settings, reloaded at every start;
    // settle and idle follow the live channel again so reacquisition uses the selected pin
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            held_clk_reg <= CTRL_RESET.clock_sel;
            held_channel_reg <= CTRL_RESET.channel_select;
        end else begin
            held_clk_reg <= held_clk_next;
            held_channel_reg <= held_channel_next;
        end
    end

endmodule : adc_control

// ==== tb/adc_control_assertions.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module adc_control_assertions
    import adc_pkg::*;
#(
    parameter int CHANNEL_COUNT = 8,
    parameter int RC_HALF_CYCLES = ADC_RC_HALF_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // analog front end and completion interrupt
    input wire logic compare_in,
    input wire adc_front_type front_out,
    input wire logic conv_done_irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    wire wr_cfg = reg_write_in && reg_addr_in == ADC_PINCFG_OFFSET;
    wire wr_ctl = reg_write_in && reg_addr_in == ADC_CTRL_OFFSET;
    // settings 001, 011, 101 borrow pin three as reference
    wire vref_w = reg_wdata_in[0] && reg_wdata_in[2:1] != 2'h3;

    a_cfg_upper_zero: assert property (
        $past(reg_read_in) && $past(reg_addr_in) == ADC_PINCFG_OFFSET |-> reg_rdata_out[7:3] == 5'h00)
        else $error("pin config upper bits not zero");
    a_go_needs_power: assert property (
        $past(reg_read_in) && $past(reg_addr_in) == ADC_CTRL_OFFSET
        |-> reg_rdata_out[1] == 1'b0 && (reg_rdata_out[2] == 1'b0 || reg_rdata_out[0] == 1'b1))
        else $error("go flag set while powered off");
    a_vref_follows: assert property (
        wr_cfg ##1 !wr_cfg |=> front_out.vref_external == $past(vref_w, 2))
        else $error("reference source wrong");
    a_all_digital: assert property (
        wr_cfg && reg_wdata_in[2:1] == 2'h3 ##1 !wr_cfg |=> front_out.analog_mask == 8'h00)
        else $error("analog pins left in all digital setting");
    a_off_idle: assert property (
        wr_ctl && !reg_wdata_in[0] ##1 !wr_ctl |=> !front_out.powered && !front_out.sampling)
        else $error("converter active while off");
    a_settle_gap: assert property (
        $rose(front_out.sampling) && $past(front_out.powered)
        |-> !$past(front_out.sampling, 2) && !$past(front_out.sampling, 3) && !$past(front_out.sampling, 4))
        else $error("acquisition restarted too early");
    a_irq_masked: assert property (
        reg_write_in && reg_addr_in == ADC_ENABLE_OFFSET && !reg_wdata_in[ADC_DONE_BIT] |=> !conv_done_irq_out)
        else $error("interrupt raised while disabled");
    a_trial_start: assert property (
        $fell(front_out.sampling) && front_out.powered |-> ##[0:1] front_out.trial == 8'h80)
        else $error("conversion did not start at mid scale");
endmodule : adc_control_assertions

bind adc_control adc_control_assertions #(.CHANNEL_COUNT(CHANNEL_COUNT), .RC_HALF_CYCLES(RC_HALF_CYCLES)) u_chk (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .compare_in(compare_in), .front_out(front_out), .conv_done_irq_out(conv_done_irq_out));

// ==== tb/adc_front_model.sv ====
// behavioural sample-and-hold and comparator
`timescale 1ns/1ps
module adc_front_model
    import adc_pkg::*;
(
    // clock
    input wire logic sys_clk_in,
    // from the converter, and the analog channel levels
    input wire adc_front_type front_in,
    input wire logic [7:0][7:0] level_in,
    // comparator result
    output logic compare_out
);
    logic toggle_reg = 1'b0;
    // an unpowered comparator gives no stable answer, so it wobbles every cycle
    always @(posedge sys_clk_in) begin
        toggle_reg <= ~toggle_reg;
    end
    assign compare_out = front_in.powered ? (level_in[front_in.channel] >= front_in.trial) : toggle_reg;
endmodule : adc_front_model

// ==== tb/adc_control_and_port_config_bench.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module adc_control_and_port_config_bench;
    import adc_pkg::*;
    localparam int RC_HALF = 2;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic compare_in;
    adc_front_type front_out;
    adc_front_type front_small;
    logic conv_done_irq_out;
    logic [7:0][7:0] level = '0;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    adc_control #(.CHANNEL_COUNT(8), .RC_HALF_CYCLES(RC_HALF)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .compare_in(compare_in), .front_out(front_out), .conv_done_irq_out(conv_done_irq_out));
    adc_front_model u_front (.sys_clk_in(sys_clk_in), .front_in(front_out), .level_in(level),
        .compare_out(compare_in));
    // the small pin-count variant shares every input but has only five channels
    adc_control #(.CHANNEL_COUNT(5), .RC_HALF_CYCLES(RC_HALF)) dut_small (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(),
        .compare_in(compare_in), .front_out(front_small), .conv_done_irq_out());

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // whole run needs a few thousand cycles at most
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        @(negedge sys_clk_in);
        `CHK(what, e, reg_rdata_out)
    endtask : rc

    // waits at most lim cycles for sampling to return, gives cycles waited
    task automatic wait_sampling(input int lim, output int n);
        for (n = 0; n < lim && front_out.sampling !== 1'b1; n++) @(negedge sys_clk_in);
    endtask : wait_sampling

    function automatic logic [7:0] mask_of(input logic [2:0] c);
        case (c)
            3'h0: return 8'hff;
            3'h1: return 8'hf7;
            3'h2: return 8'h1f;
            3'h3: return 8'h17;
            3'h4: return 8'h0b;
            3'h5: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : mask_of

    initial begin
        logic [7:0] addrs [6] = '{ADC_RESULT_OFFSET, ADC_CTRL_OFFSET, ADC_PINCFG_OFFSET,
            ADC_FLAG_OFFSET, ADC_ENABLE_OFFSET, 8'h55};
        logic [2:0] ch;
        int t0, h, n;
        void'($urandom(32'h53f5871c));
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        foreach (addrs[i]) rc(addrs[i], 8'h00, "reset value");
        wr(8'h55, 8'hff);
        rc(8'h55, 8'h00, "unmapped");
        wr(ADC_PINCFG_OFFSET, 8'hff);
        rc(ADC_PINCFG_OFFSET, 8'h07, "pin config");
        wr(ADC_CTRL_OFFSET, 8'hfe);
        rc(ADC_CTRL_OFFSET, 8'hf8, "go while off");
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wr(ADC_PINCFG_OFFSET, 8'(c));
            repeat (2) @(negedge sys_clk_in);
            `CHK("analog mask", mask_of(3'(c)), front_out.analog_mask)
            `CHK("vref", 1'(c == 1 || c == 3 || c == 5), front_out.vref_external)
            `CHK("small variant mask", mask_of(3'(c)) & 8'h1f, front_small.analog_mask)
        end
        $display("test pin config done");
        for (int s = 0; s < 4; s++) begin
            ch = 3'($urandom_range(7));
            foreach (level[i]) level[i] = 8'($urandom());
            if (s == 0) level[ch] = 8'h00;
            if (s == 3) level[ch] = 8'hff;
            h = (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 16 : RC_HALF;
            wr(ADC_PINCFG_OFFSET, 8'h00);
            wr(ADC_CTRL_OFFSET, {2'(s), ch, 3'b001});
            wr(ADC_FLAG_OFFSET, 8'h00);
            wr(ADC_ENABLE_OFFSET, 8'h40);
            repeat (8) @(negedge sys_clk_in);
            `CHK("channel", ch, front_out.channel)
            wr(ADC_CTRL_OFFSET, {2'(s), ch, 3'b101});
            @(negedge sys_clk_in);
            t0 = cyc;
            rc(ADC_CTRL_OFFSET, {2'(s), ch, 3'b101}, "go during conversion");
            for (n = 0; n < 2000 && conv_done_irq_out !== 1'b1; n++) @(negedge sys_clk_in);
            `CHK("conversion length", 1'b1, 1'(cyc - t0 >= 19 * h && cyc - t0 <= 19 * h + 3))
            wait_sampling(500, n);
            `CHK("settle", 1'b1, 1'(n >= 4 * h - 2 && n <= 4 * h + 3))
            rc(ADC_CTRL_OFFSET, {2'(s), ch, 3'b001}, "go after completion");
            rc(ADC_RESULT_OFFSET, level[ch], "result");
            rc(ADC_FLAG_OFFSET, 8'h40, "done flag");
            wr(ADC_FLAG_OFFSET, 8'h00);
            repeat (2) @(negedge sys_clk_in);
            `CHK("irq cleared", 1'b0, conv_done_irq_out)
            $display("test conversion clock %0d done", s);
        end
        wr(ADC_RESULT_OFFSET, 8'h5a);
        wr(ADC_CTRL_OFFSET, 8'h55);
        repeat (10) @(negedge sys_clk_in);
        wr(ADC_CTRL_OFFSET, 8'h51);
        wait_sampling(100, n);
        `CHK("abort settle", 1'b1, 1'(n >= 12 && n <= 20))
        rc(ADC_RESULT_OFFSET, 8'h5a, "result kept");
        rc(ADC_FLAG_OFFSET, 8'h00, "no flag on abort");
        `CHK("no irq on abort", 1'b0, conv_done_irq_out)
        $display("test abort done");
        wr(ADC_FLAG_OFFSET, 8'h40);
        repeat (2) @(negedge sys_clk_in);
        `CHK("irq on flag", 1'b1, conv_done_irq_out)
        wr(ADC_ENABLE_OFFSET, 8'h00);
        repeat (2) @(negedge sys_clk_in);
        `CHK("irq masked", 1'b0, conv_done_irq_out)
        rc(ADC_FLAG_OFFSET, 8'h40, "flag kept when masked");
        $display("test interrupt mask done");
        complete_run();
    end
endmodule : adc_control_and_port_config_bench
